/* verilog/mdoc_pkg.sv */
// constants, types and lookup tables of the motion dwell controller
package mdoc_pkg;

	// =========================================================
	// clock and timing
	localparam int CLK_HZ = 50_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int STORE_HOLD_MS = 1000;
	localparam int QUIET_MS = 500;
	localparam int BIT_US = 10;
	localparam int BIT_CYCLES = CLK_HZ / 1_000_000 * BIT_US;

	// =========================================================
	// widths
	localparam int AMP_W = 14;
	localparam int DWELL_W = 20;
	localparam int ADDR_W = 8;
	localparam int NV_W = 8;

	// =========================================================
	// register map
	localparam logic [ADDR_W-1:0] CFG_ADDR = 8'h00;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
	localparam int CFG_SENS_LSB = 0;
	localparam int CFG_DWELL_LSB = 4;
	localparam int CFG_MODE_BIT = 8;
	localparam int CFG_COMMIT_BIT = 31;
	localparam int ST_OUT_BIT = 0;
	localparam int ST_STATE_LSB = 1;
	localparam int ST_BUSY_BIT = 3;
	localparam int ST_MAG_LSB = 16;

	// =========================================================
	// stored setting word
	localparam int NV_SENS_LSB = 0;
	localparam int NV_DWELL_LSB = 3;
	localparam int NV_MODE_BIT = 7;

	// =========================================================
	// settings
	typedef enum logic [2:0]
	{
		SENS_MIN = 3'h0,
		SENS_LOW = 3'h1,
		SENS_MED = 3'h2,
		SENS_HIGH = 3'h3,
		SENS_MAX = 3'h4
	} mdoc_sens_type;

	localparam logic [3:0] DWELL_IDX_200MS = 4'h0;
	localparam logic [3:0] DWELL_IDX_DEF = 4'h1;
	localparam logic [3:0] DWELL_IDX_30S = 4'h5;
	localparam logic [3:0] DWELL_IDX_LAST = 4'h9;
	localparam logic MODE_RETRIG = 1'b0;
	localparam logic MODE_SINGLE = 1'b1;

	// strap codes from the resistance front end
	localparam logic [2:0] STRAP_SHORT = 3'h0;
	localparam logic [2:0] STRAP_2K7 = 3'h1;
	localparam logic [2:0] STRAP_6K8 = 3'h2;
	localparam logic [2:0] STRAP_15K = 3'h3;
	localparam logic [2:0] STRAP_39K = 3'h4;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'h0,
		ST_ON = 2'h1,
		ST_LOCK = 2'h3
	} mdoc_state_type;

	// =========================================================
	// tables
	function automatic logic [DWELL_W-1:0] dwell_ms(input logic [3:0] idx);
		unique case (idx)
			4'h0: dwell_ms = 20'h000C8;
			4'h1: dwell_ms = 20'h003E8;
			4'h2: dwell_ms = 20'h007D0;
			4'h3: dwell_ms = 20'h01388;
			4'h4: dwell_ms = 20'h02710;
			4'h5: dwell_ms = 20'h07530;
			4'h6: dwell_ms = 20'h0EA60;
			4'h7: dwell_ms = 20'h1D4C0;
			4'h8: dwell_ms = 20'h493E0;
			default: dwell_ms = 20'h927C0;
		endcase
	endfunction : dwell_ms

	// higher sensitivity, lower threshold
	function automatic logic [AMP_W-1:0] threshold(input logic [2:0] sens);
		unique case (sens)
			SENS_MIN: threshold = 14'h0400;
			SENS_LOW: threshold = 14'h0200;
			SENS_MED: threshold = 14'h0100;
			SENS_HIGH: threshold = 14'h0080;
			default: threshold = 14'h0040;
		endcase
	endfunction : threshold

endpackage : mdoc_pkg

/* verilog/mdoc_link_if.sv */
// signals between the controller core, sample receiver and dwell timer
`timescale 1ns/1ps
interface mdoc_link_if;
	import mdoc_pkg::*;
	logic signed [AMP_W-1:0] amp;
	logic amp_valid;
	logic dwell_start;
	logic [DWELL_W-1:0] dwell_len;
	logic dwell_busy;
	logic dwell_done;

	modport rx (output amp, output amp_valid);
	modport timer (input dwell_start, input dwell_len,
		output dwell_busy, output dwell_done);
	modport core (input amp, input amp_valid, output dwell_start,
		output dwell_len, input dwell_busy, input dwell_done);
endinterface : mdoc_link_if

/* verilog/mdoc_serial_rx.sv */
// serial amplitude frame receiver for the pyroelectric sensor
`timescale 1ns/1ps
module mdoc_serial_rx
#(
	parameter int BIT_CYCLES = mdoc_pkg::BIT_CYCLES
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sensor_data,
	mdoc_link_if.rx link
);
	import mdoc_pkg::*;

	if (BIT_CYCLES < 4)
		$error("BIT_CYCLES too small");

	localparam int CW = $clog2(BIT_CYCLES + 1);
	localparam int NW = $clog2(AMP_W + 2);

	logic sync_a;
	logic sync_b;
	logic line_prev;
	logic busy;
	logic [CW-1:0] cnt;
	logic [NW-1:0] bitn;
	logic [AMP_W-1:0] shift;

	// =========================================================
	// pin synchroniser
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			line_prev <= 1'b0;
		end
		else
		begin
			sync_a <= sensor_data;
			sync_b <= sync_a;
			line_prev <= sync_b;
		end

	// =========================================================
	// frame: high start bit, then AMP_W bits msb first, mid-bit sampling
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			busy <= 1'b0;
			cnt <= '0;
			bitn <= '0;
			shift <= '0;
			link.amp <= '0;
			link.amp_valid <= 1'b0;
		end
		else
		begin
			link.amp_valid <= 1'b0;
			if (!busy)
			begin
				if (sync_b && !line_prev)
				begin
					busy <= 1'b1;
					cnt <= CW'(BIT_CYCLES / 2);
					bitn <= '0;
				end
			end
			else if (cnt != '0)
				cnt <= cnt - 1'b1;
			else if (bitn == '0 && !sync_b)
				busy <= 1'b0; // glitch, not a start bit
			else
			begin
				cnt <= CW'(BIT_CYCLES - 1);
				bitn <= bitn + 1'b1;
				if (bitn != '0)
					shift <= {shift[AMP_W-2:0], sync_b};
				if (bitn == NW'(AMP_W))
				begin
					busy <= 1'b0;
					link.amp <= {shift[AMP_W-2:0], sync_b};
					link.amp_valid <= 1'b1;
				end
			end
		end

endmodule : mdoc_serial_rx

/* verilog/mdoc_dwell_timer.sv */
// dwell interval timer with its own millisecond prescaler
`timescale 1ns/1ps
module mdoc_dwell_timer
#(
	parameter int TICK_CYCLES = mdoc_pkg::TICK_CYCLES
)
(
	input wire logic pclk,
	input wire logic presetn,
	mdoc_link_if.timer link
);
	import mdoc_pkg::*;

	if (TICK_CYCLES < 2)
		$error("TICK_CYCLES too small");

	localparam int PW = $clog2(TICK_CYCLES);

	logic [PW-1:0] pre;
	logic [DWELL_W-1:0] remain;

	// restarting the prescaler makes the interval exact to the cycle
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pre <= '0;
			remain <= '0;
			link.dwell_busy <= 1'b0;
			link.dwell_done <= 1'b0;
		end
		else
		begin
			link.dwell_done <= 1'b0;
			if (link.dwell_start)
			begin
				pre <= '0;
				remain <= link.dwell_len;
				link.dwell_busy <= 1'b1;
			end
			else if (link.dwell_busy)
			begin
				if (pre != PW'(TICK_CYCLES - 1))
					pre <= pre + 1'b1;
				else
				begin
					pre <= '0;
					remain <= remain - 1'b1;
					if (remain == DWELL_W'(1))
					begin
						link.dwell_busy <= 1'b0;
						link.dwell_done <= 1'b1;
					end
				end
			end
		end

endmodule : mdoc_dwell_timer

/* verilog/mdoc_motion_ctrl.sv */
// motion dwell output controller top: apb, settings, strap store, output
//
// What this block does
// - decode sensor serial amplitudes; assert output when they show motion.
// - only changing infrared triggers; a constant level never does.
// - output low with no motion, high while motion is signalled.
// - five sensitivity levels, medium by default.
// - ten dwell times, 200 ms up to 10 minutes.
// - unprogrammed dwell setting means one second.
// - retriggerable: new motion while high restarts the dwell timer.
// - retriggerable: output stays high while motion keeps arriving in time.
// - retriggerable is the default mode.
// - 200 ms dwell never retriggers, whatever the mode.
// - single event: high on detection, low after exactly one dwell.
// - single event: after low, wait for quiet before new events.
// - store pad grounded one second then released commits the setting.
// - both select pads open: strap picks sensitivity.
// - one select pad grounded: strap picks dwell time.
// - both pads grounded: strap picks mode, or restores all defaults.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
module mdoc_motion_ctrl
#(
	parameter int TICK_CYCLES = mdoc_pkg::TICK_CYCLES,
	parameter int BIT_CYCLES = mdoc_pkg::BIT_CYCLES
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [mdoc_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sensor_data,
	input wire logic select_pad_a_n,
	input wire logic select_pad_b_n,
	input wire logic [2:0] value_strap_code,
	input wire logic store_pad_n,
	input wire logic [mdoc_pkg::NV_W-1:0] nv_data_in,
	output logic [mdoc_pkg::NV_W-1:0] nv_data_out,
	output logic nv_write,
	output logic motion_out
);
	import mdoc_pkg::*;

	if (TICK_CYCLES < 2)
		$error("TICK_CYCLES too small");

	localparam int PW = $clog2(TICK_CYCLES);
	localparam int NPIN = 6;
	localparam int SW = $clog2(STORE_HOLD_MS + 1);
	localparam int QW = $clog2(QUIET_MS + 1);

	mdoc_link_if link ();

	mdoc_serial_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx
	(
		.pclk(pclk),
		.presetn(presetn),
		.sensor_data(sensor_data),
		.link(link.rx)
	);

	mdoc_dwell_timer #(.TICK_CYCLES(TICK_CYCLES)) u_dwell
	(
		.pclk(pclk),
		.presetn(presetn),
		.link(link.timer)
	);

	// =========================================================
	// pad synchronisers
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_s1;
	logic [NPIN-1:0] pin_s2;
	assign pin_raw = {store_pad_n, select_pad_b_n, select_pad_a_n,
		value_strap_code};

	for (genvar i = 0; i < NPIN; i++)
	begin : g_sync
		always_ff @(posedge pclk or negedge presetn)
			if (!presetn)
			begin
				pin_s1[i] <= 1'b1;
				pin_s2[i] <= 1'b1;
			end
			else
			begin
				pin_s1[i] <= pin_raw[i];
				pin_s2[i] <= pin_s1[i];
			end
	end

	logic [2:0] strap;
	logic pad_a_gnd;
	logic pad_b_gnd;
	logic store_gnd;
	assign strap = pin_s2[2:0];
	assign pad_a_gnd = !pin_s2[3];
	assign pad_b_gnd = !pin_s2[4];
	assign store_gnd = !pin_s2[5];

	// =========================================================
	// millisecond tick for store hold and quiet timing
	logic [PW-1:0] tick_cnt;
	logic ms_tick;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			tick_cnt <= '0;
			ms_tick <= 1'b0;
		end
		else
		begin
			ms_tick <= tick_cnt == PW'(TICK_CYCLES - 1);
			tick_cnt <= (tick_cnt == PW'(TICK_CYCLES - 1)) ? '0
				: tick_cnt + 1'b1;
		end

	// =========================================================
	// active settings
	logic [2:0] sens;
	logic [3:0] dwell_idx;
	logic mode;
	logic loaded;
	logic store_armed;
	logic [SW-1:0] store_cnt;
	logic store_prev;
	logic store_fire;
	logic apb_wr;
	logic apb_commit;
	logic [NV_W-1:0] nv_word;

	assign apb_wr = psel && penable && pready && pwrite && !pslverr;
	assign apb_commit = apb_wr && paddr == CFG_ADDR
		&& pwdata[CFG_COMMIT_BIT];
	assign store_fire = store_prev && !store_gnd && store_armed;
	assign nv_word = {mode, dwell_idx, sens};

	// hold-time counter; a full second of hold arms the commit, release fires it
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			store_cnt <= '0;
			store_armed <= 1'b0;
			store_prev <= 1'b0;
		end
		else
		begin
			store_prev <= store_gnd;
			if (!store_gnd)
			begin
				store_cnt <= '0;
				store_armed <= 1'b0;
			end
			else if (ms_tick && !store_armed)
			begin
				store_cnt <= store_cnt + 1'b1;
				if (store_cnt == SW'(STORE_HOLD_MS - 1))
					store_armed <= 1'b1;
			end
		end

	// reset gives defaults; the stored word is taken just after release
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			loaded <= 1'b0;
			sens <= SENS_MED;
			dwell_idx <= DWELL_IDX_DEF;
			mode <= MODE_RETRIG;
		end
		else if (!loaded)
		begin
			loaded <= 1'b1;
			// out-of-range sens and dwell fields fall back to defaults; the mode bit is taken as stored
			if (nv_data_in[NV_SENS_LSB +: 3] <= SENS_MAX)
				sens <= nv_data_in[NV_SENS_LSB +: 3];
			if (nv_data_in[NV_DWELL_LSB +: 4] <= DWELL_IDX_LAST)
				dwell_idx <= nv_data_in[NV_DWELL_LSB +: 4];
			mode <= nv_data_in[NV_MODE_BIT];
		end
		else if (apb_wr && paddr == CFG_ADDR)
		begin
			if (pwdata[CFG_SENS_LSB +: 3] <= SENS_MAX)
				sens <= pwdata[CFG_SENS_LSB +: 3];
			if (pwdata[CFG_DWELL_LSB +: 4] <= DWELL_IDX_LAST)
				dwell_idx <= pwdata[CFG_DWELL_LSB +: 4];
			mode <= pwdata[CFG_MODE_BIT];
		end
		else if (store_fire)
		begin
			unique case ({pad_b_gnd, pad_a_gnd})
				2'b00:
					if (strap <= STRAP_39K)
						sens <= (strap == STRAP_SHORT) ? SENS_MED
							: (strap == STRAP_2K7) ? SENS_MIN
							: (strap == STRAP_6K8) ? SENS_LOW
							: (strap == STRAP_15K) ? SENS_HIGH
							: SENS_MAX;
				2'b01:
					if (strap <= STRAP_39K)
						dwell_idx <= (strap == STRAP_2K7) ? DWELL_IDX_200MS
							: (strap == STRAP_SHORT) ? DWELL_IDX_DEF
							: 4'(strap);
				2'b10:
					if (strap <= STRAP_39K)
						dwell_idx <= (strap == STRAP_SHORT) ? DWELL_IDX_30S
							: DWELL_IDX_30S + 4'(strap);
				2'b11:
					if (strap == STRAP_SHORT)
					begin
						sens <= SENS_MED;
						dwell_idx <= DWELL_IDX_DEF;
						mode <= MODE_RETRIG;
					end
					else if (strap == STRAP_2K7)
						mode <= MODE_RETRIG;
					else if (strap == STRAP_6K8)
						mode <= MODE_SINGLE;
			endcase
		end

	// one cycle late, so the word carries the new setting
	logic commit_q;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			commit_q <= 1'b0;
			nv_write <= 1'b0;
			nv_data_out <= '0;
		end
		else
		begin
			commit_q <= store_fire || apb_commit;
			nv_write <= commit_q;
			nv_data_out <= nv_word;
		end

	// =========================================================
	// motion judgement on the change between successive samples
	logic signed [AMP_W-1:0] amp_prev;
	logic signed [AMP_W:0] delta;
	logic [AMP_W:0] mag;
	logic have_prev;
	logic [AMP_W-1:0] last_mag;
	logic detect;
	assign delta = (AMP_W + 1)'(link.amp) - (AMP_W + 1)'(amp_prev);
	assign mag = delta[AMP_W] ? (AMP_W + 1)'(-delta) : delta;
	// a steady level gives zero change and never detects
	assign detect = link.amp_valid && have_prev
		&& mag > {1'b0, threshold(sens)};

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			amp_prev <= '0;
			have_prev <= 1'b0;
			last_mag <= '0;
		end
		else if (link.amp_valid)
		begin
			amp_prev <= link.amp;
			have_prev <= 1'b1;
			last_mag <= mag[AMP_W-1:0];
		end

	// =========================================================
	// output state machine
	mdoc_state_type state;
	logic [QW-1:0] quiet_cnt;
	logic retrig_ok;
	assign retrig_ok = mode == MODE_RETRIG
		&& dwell_idx != DWELL_IDX_200MS;
	assign link.dwell_len = dwell_ms(dwell_idx);
	assign link.dwell_start = (state == ST_IDLE && detect)
		|| (state == ST_ON && detect && retrig_ok);

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			state <= ST_IDLE;
			motion_out <= 1'b0;
			quiet_cnt <= '0;
		end
		else
		begin
			unique case (state)
				ST_IDLE:
					if (detect)
					begin
						state <= ST_ON;
						motion_out <= 1'b1;
					end
				ST_ON:
					// a restart in the expiry cycle keeps the output high
					if (link.dwell_done && !link.dwell_start)
					begin
						motion_out <= 1'b0;
						quiet_cnt <= '0;
						state <= (mode == MODE_SINGLE) ? ST_LOCK : ST_IDLE;
					end
				ST_LOCK:
					if (detect)
						quiet_cnt <= '0;
					else if (ms_tick)
					begin
						quiet_cnt <= quiet_cnt + 1'b1;
						if (quiet_cnt == QW'(QUIET_MS - 1))
							state <= ST_IDLE;
					end
				default:
					state <= ST_IDLE;
			endcase
		end

	// =========================================================
	// apb slave: one wait-free access phase, pready from a flop
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && paddr != CFG_ADDR
				&& paddr != STATUS_ADDR;
			prdata <= '0;
			if (psel && !penable && !pwrite)
			begin
				if (paddr == CFG_ADDR)
				begin
					prdata[CFG_SENS_LSB +: 3] <= sens;
					prdata[CFG_DWELL_LSB +: 4] <= dwell_idx;
					prdata[CFG_MODE_BIT] <= mode;
				end
				else if (paddr == STATUS_ADDR)
				begin
					prdata[ST_OUT_BIT] <= motion_out;
					prdata[ST_STATE_LSB +: 2] <= state;
					prdata[ST_BUSY_BIT] <= link.dwell_busy;
					prdata[ST_MAG_LSB +: AMP_W] <= last_mag;
				end
			end
		end

endmodule : mdoc_motion_ctrl

/* verif/mdoc_motion_checker.sv */
// port-level assertions for the motion dwell output controller
`timescale 1ns/1ps
module mdoc_motion_checker
#(
	parameter int TICK_CYCLES = mdoc_pkg::TICK_CYCLES,
	parameter int BIT_CYCLES = mdoc_pkg::BIT_CYCLES
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [mdoc_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sensor_data,
	input wire logic select_pad_a_n,
	input wire logic select_pad_b_n,
	input wire logic [2:0] value_strap_code,
	input wire logic store_pad_n,
	input wire logic [mdoc_pkg::NV_W-1:0] nv_data_in,
	input wire logic [mdoc_pkg::NV_W-1:0] nv_data_out,
	input wire logic nv_write,
	input wire logic motion_out
);
	import mdoc_pkg::*;

	int since_rise;
	int high_cnt;
	int hold_cnt;

	// =========================================================
	// helper counters
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			since_rise <= 1000;
		else
			since_rise <= $rose(sensor_data) ? 0 : since_rise + 1;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			high_cnt <= 0;
		else
			high_cnt <= motion_out ? high_cnt + 1 : 0;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			hold_cnt <= 0;
		else
			hold_cnt <= store_pad_n ? 0 : hold_cnt + 1;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// =========================================================
	// assertions
	a_low_after_reset: assert property (
		$rose(presetn) |-> !motion_out [*8])
		else $error("output high right after reset");
	a_rise_after_frame: assert property (
		$rose(motion_out) |-> since_rise <= 15 * BIT_CYCLES + 12)
		else $error("output rose with no sensor frame");
	a_min_dwell: assert property (
		$fell(motion_out) |-> high_cnt >= 199 * TICK_CYCLES)
		else $error("output high shorter than shortest dwell");
	a_ready_next: assert property (
		psel && !penable |=> pready)
		else $error("no ready in access cycle");
	a_ready_single: assert property (
		pready |=> !pready)
		else $error("ready held too long");
	a_err_unmapped: assert property (
		pready && paddr != CFG_ADDR && paddr != STATUS_ADDR
		|-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_ok_mapped: assert property (
		pready && (paddr == CFG_ADDR || paddr == STATUS_ADDR) |-> !pslverr)
		else $error("mapped access refused");
	a_store_pulse: assert property (
		nv_write |=> !nv_write)
		else $error("store write longer than one cycle");
	a_store_commit: assert property (
		$rose(store_pad_n) && hold_cnt > 1002 * TICK_CYCLES
		|-> ##[1:8] nv_write)
		else $error("long store hold not committed");

	c_motion: cover property ($rose(motion_out));
	c_store: cover property (nv_write);
	c_refused: cover property (pready && pslverr);
endmodule : mdoc_motion_checker

bind mdoc_motion_ctrl mdoc_motion_checker #(
	.TICK_CYCLES(TICK_CYCLES),
	.BIT_CYCLES(BIT_CYCLES)
) i_chk (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sensor_data(sensor_data), .select_pad_a_n(select_pad_a_n),
	.select_pad_b_n(select_pad_b_n), .value_strap_code(value_strap_code),
	.store_pad_n(store_pad_n), .nv_data_in(nv_data_in),
	.nv_data_out(nv_data_out), .nv_write(nv_write),
	.motion_out(motion_out)
);

/* verif/mdoc_sensor_model.sv */
// behavioural pyroelectric sensor sending serial amplitude frames
`timescale 1ns/1ps
module mdoc_sensor_model
#(
	parameter int BIT_CYCLES = 8
)
(
	input wire logic pclk,
	output logic sensor_data
);
	import mdoc_pkg::*;

	initial sensor_data = 1'b0;

	// =========================================================
	// frame: start bit, amplitude msb first, then idle low for gap
	task automatic send(input logic [AMP_W-1:0] amp, input int gap);
		logic [AMP_W:0] frame;
		frame = {1'b1, amp};
		for (int i = AMP_W; i >= 0; i--)
		begin
			@(posedge pclk);
			sensor_data <= frame[i];
			repeat (BIT_CYCLES - 1) @(posedge pclk);
		end
		@(posedge pclk);
		sensor_data <= 1'b0;
		repeat (gap) @(posedge pclk);
	endtask : send
endmodule : mdoc_sensor_model

/* verif/mdoc_motion_ctrl_tb.sv */
// self-checking bench of the motion dwell output controller
`timescale 1ns/1ps
module mdoc_motion_ctrl_tb;
	import mdoc_pkg::*;

	// short prescalers keep a 1 s dwell at ten thousand cycles
	localparam int TICK = 10;
	localparam int BITC = 8;

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sensor_data;
	logic select_pad_a_n = 1'b1;
	logic select_pad_b_n = 1'b1;
	logic [2:0] value_strap_code = 3'h7;
	logic store_pad_n = 1'b1;
	// out-of-range stored fields must fall back to defaults
	logic [NV_W-1:0] nv_data_in = 8'h7F;
	logic [NV_W-1:0] nv_data_out;
	logic nv_write;
	logic motion_out;
	logic [31:0] rd;
	logic err;
	int last_amp;
	int n_fail = 0;
	int samples_checked = 0;

	always #10 pclk = ~pclk;

	mdoc_motion_ctrl #(.TICK_CYCLES(TICK), .BIT_CYCLES(BITC)) i_dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sensor_data(sensor_data), .select_pad_a_n(select_pad_a_n),
		.select_pad_b_n(select_pad_b_n),
		.value_strap_code(value_strap_code), .store_pad_n(store_pad_n),
		.nv_data_in(nv_data_in), .nv_data_out(nv_data_out),
		.nv_write(nv_write), .motion_out(motion_out)
	);

	mdoc_sensor_model #(.BIT_CYCLES(BITC)) i_sensor (
		.pclk(pclk), .sensor_data(sensor_data)
	);

	// =========================================================
	// helpers
	function automatic logic [31:0] ext(input logic x);
		return {31'h0, x};
	endfunction : ext

	function automatic logic [31:0] in_rng(int v, int lo, int hi);
		return {31'h0, v >= lo && v <= hi};
	endfunction : in_rng

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test

	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		check("apb ready", ext(pready), 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic sense(input int a);
		last_amp = a;
		i_sensor.send(a[AMP_W-1:0], 16);
	endtask : sense

	task automatic wait_out(input logic v, output int t);
		t = 0;
		while (motion_out !== v && t < 12000)
		begin
			@(posedge pclk);
			t++;
		end
	endtask : wait_out

	// =========================================================
	// scenarios
	task automatic t_reset;
		repeat (10) @(posedge pclk);
		check("out in reset", ext(motion_out), 32'h0);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, CFG_ADDR, 32'h0);
		check("cfg defaults", rd, 32'h0000_0012);
		apb(1'b0, 8'h08, 32'h0);
		check("unmapped err", ext(err), 32'h1);
		check("unmapped data", rd, 32'h0);
		apb(1'b0, STATUS_ADDR, 32'h0);
		check("status idle", rd, 32'h0);
		check("out idle", ext(motion_out), 32'h0);
	endtask : t_reset

	task automatic t_static;
		int t;
		sense(32'h1000);
		sense(32'h1000);
		check("static level", ext(motion_out), 32'h0);
		sense(32'h1100);
		check("at threshold", ext(motion_out), 32'h0);
		sense(32'h1201);
		check("over threshold", ext(motion_out), 32'h1);
		apb(1'b0, STATUS_ADDR, 32'h0);
		check("status on", rd, 32'h0101_000B);
		wait_out(1'b0, t);
		check("dwell 1 s", in_rng(t, 9960, 10010), 32'h1);
	endtask : t_static

	task automatic t_retrig;
		int t;
		sense(32'h1000);
		repeat (3000) @(posedge pclk);
		sense(32'h1201);
		check("held high", ext(motion_out), 32'h1);
		wait_out(1'b0, t);
		check("restarted dwell", in_rng(t, 9960, 10010), 32'h1);
	endtask : t_retrig

	task automatic t_short;
		int t;
		apb(1'b1, CFG_ADDR, 32'h0000_0002);
		sense(32'h1000);
		repeat (1000) @(posedge pclk);
		sense(32'h1201);
		wait_out(1'b0, t);
		check("no retrigger", in_rng(t, 820, 880), 32'h1);
	endtask : t_short

	task automatic t_single;
		int t;
		apb(1'b1, CFG_ADDR, 32'h0000_0102);
		sense(32'h1000);
		repeat (1000) @(posedge pclk);
		sense(32'h1201);
		wait_out(1'b0, t);
		check("one dwell", in_rng(t, 820, 880), 32'h1);
		sense(32'h1000);
		check("locked out", ext(motion_out), 32'h0);
		repeat (QUIET_MS * TICK + 200) @(posedge pclk);
		sense(32'h1201);
		check("after quiet", ext(motion_out), 32'h1);
		wait_out(1'b0, t);
		repeat (QUIET_MS * TICK + 200) @(posedge pclk);
	endtask : t_single

	task automatic t_sens;
		int thr[5] = '{32'h400, 32'h200, 32'h100, 32'h80, 32'h40};
		int t;
		for (int s = 0; s < 5; s++)
		begin
			apb(1'b1, CFG_ADDR, s);
			sense(last_amp - thr[s]);
			check("at level", ext(motion_out), 32'h0);
			sense(last_amp - thr[s] - 1);
			check("over level", ext(motion_out), 32'h1);
			wait_out(1'b0, t);
		end
	endtask : t_sens

	task automatic t_store(input logic pa, input logic pb,
		input logic [2:0] code, input logic [7:0] nv);
		int n;
		n = 0;
		select_pad_a_n <= pa;
		select_pad_b_n <= pb;
		value_strap_code <= code;
		repeat (5) @(posedge pclk);
		store_pad_n <= 1'b0;
		repeat (1000 * TICK + 30) @(posedge pclk);
		store_pad_n <= 1'b1;
		while (nv_write !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		check("store pulse", ext(nv_write), 32'h1);
		check("stored word", {24'h0, nv_data_out}, {24'h0, nv});
		select_pad_a_n <= 1'b1;
		select_pad_b_n <= 1'b1;
		value_strap_code <= 3'h7;
		apb(1'b0, CFG_ADDR, 32'h0);
		check("cfg stored", rd, {23'h0, nv[7:3], 1'b0, nv[2:0]});
	endtask : t_store

	// =========================================================
	// run
	initial
	begin
		t_reset();
		t_static();
		t_retrig();
		t_short();
		t_single();
		t_sens();
		t_store(1'b0, 1'b1, STRAP_6K8, 8'h14);
		t_store(1'b1, 1'b1, STRAP_15K, 8'h13);
		t_store(1'b0, 1'b0, STRAP_6K8, 8'h93);
		t_store(1'b0, 1'b0, STRAP_SHORT, 8'h0A);
		stop_test();
	end

	// full run needs roughly 92k cycles
	initial
	begin
		repeat (99000) @(posedge pclk);
		n_fail++;
		stop_test();
	end
endmodule : mdoc_motion_ctrl_tb
